// *** core/pid_cfg.svh ***
`ifndef PID_CFG_SVH
`define PID_CFG_SVH

// Descriptor field positions.
`define PID_TYPE_PC 7'h07
`define PID_TYPE_TLB 7'h02
`define PID_TYPE_HI_MSB 11
`define PID_TYPE_HI_LSB 9
`define PID_TYPE_LO_MSB 3
`define PID_TYPE_LO_LSB 0
`define PID_G_MSB 5
`define PID_G_LSB 4
`define PID_DW_BIT 6
`define PID_DR_BIT 7
`define PID_DID_MSB 31
`define PID_DID_LSB 16
`define PID_PASID_MSB 51
`define PID_PASID_LSB 32
`define PID_AM_MSB 69
`define PID_AM_LSB 64
`define PID_IH_BIT 70
`define PID_ADDR_MSB 127
`define PID_ADDR_LSB 76
`define PID_HALF_MSB 255
`define PID_HALF_LSB 128
`define PID_ADDR_BASE 7'h40
`define PID_PAGE_SHIFT 7'h0C

// Granularity codes.
`define PID_PC_DOMAIN 2'h0
`define PID_PC_PASID 2'h1
`define PID_PC_RSVD 2'h2
`define PID_PC_GLOBAL 2'h3
`define PID_TLB_RSVD 2'h0
`define PID_TLB_GLOBAL 2'h1
`define PID_TLB_DOMAIN 2'h2
`define PID_TLB_PAGE 2'h3
`define PID_TTM_LEGACY 2'h0

// Register word indexes (byte offset is four times the index).
`define PID_REG_CTRL 3'h0
`define PID_REG_STATUS 3'h1
`define PID_REG_CAP 3'h2
`define PID_REG_COUNT 3'h3

// Control register fields.
`define PID_CTRL_W256 0
`define PID_CTRL_PSI 1
`define PID_CTRL_WRITE_BUFFER_FLUSH_REQUIRED 2
`define PID_CTRL_TTM_MSB 5
`define PID_CTRL_TTM_LSB 4
`define PID_CTRL_VER_MSB 11
`define PID_CTRL_VER_LSB 8
`define PID_CTRL_RESET 32'h0000_0102
`define PID_CTRL_MASK 32'h0000_0F37

// Capability register fields.
`define PID_CAP_DOMW_MSB 4
`define PID_CAP_DOMW_LSB 0
`define PID_CAP_MAX_GUEST_ADDR_WIDTH_MSB 14
`define PID_CAP_MAX_GUEST_ADDR_WIDTH_LSB 8
`define PID_CAP_MAXAM_MSB 21
`define PID_CAP_MAXAM_LSB 16
`define PID_CAP_RESET 32'h0000_3010
`define PID_CAP_MASK 32'h0000_7F1F
`define PID_MAX_AM 6'h12
`define PID_VER_DRAIN 4'h2

// Status register fields.
`define PID_STAT_BUSY 0
`define PID_STAT_ERR 1

`endif

// *** core/pid_pkg.sv ***
package pid_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CHECK,
        ST_FLUSH,
        ST_ISSUE,
        ST_DRAIN,
        ST_DONE,
        ST_ERROR
    } pid_state_e;

    typedef logic [1:0] pid_gran_t;

    // Returns a mask with the low n bits set.
    function automatic logic [63:0] pid_low_mask(input logic [6:0] n);
        logic [63:0] m;
        m = 64'h0;
        for (int i = 0; i < 64; i++) begin
            m[i] = (7'(i) < n);
        end
        return m;
    endfunction

    // Merges write data into a register under byte enables and a writable mask.
    function automatic logic [31:0] pid_be_merge(input logic [31:0] old, input logic [31:0] wr,
                                                 input logic [3:0] be, input logic [31:0] wmask);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            for (int i = 0; i < 8; i++) begin
                if (be[b] && wmask[b * 8 + i]) begin
                    r[b * 8 + i] = wr[b * 8 + i];
                end
            end
        end
        return r;
    endfunction

endpackage

// *** core/pid_desc_check.sv ***
`timescale 1ns/100ps
`include "pid_cfg.svh"

module pid_desc_check
    import pid_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [255:0] dsc,
    input wire logic width256,
    input wire logic psiSupport,
    input wire logic [4:0] domWidth,
    input wire logic [6:0] maxGuestAddrWidth,
    output logic isPc,
    output logic isTlb,
    output logic descOk,
    output pid_gran_t gran,
    output logic [15:0] domain,
    output logic [19:0] pasid,
    output logic [51:0] pageAddr,
    output logic [5:0] addrMask,
    output logic keepStage2,
    output logic readDrain,
    output logic writeDrain
);
    logic isPc_d, isTlb_d, descOk_d, keepStage2_d, readDrain_d, writeDrain_d;
    pid_gran_t gran_d;
    logic [15:0] domain_d;
    logic [19:0] pasid_d;
    logic [51:0] pageAddr_d;
    logic [5:0] addrMask_d;
    logic isPc_q, isTlb_q, descOk_q, keepStage2_q, readDrain_q, writeDrain_q;
    pid_gran_t gran_q;
    logic [15:0] domain_q;
    logic [19:0] pasid_q;
    logic [51:0] pageAddr_q;
    logic [5:0] addrMask_q;

    always_comb begin
        logic [6:0] dscType;
        logic [63:0] keepAddr;
        logic [63:0] amMask;
        logic [63:0] domMask;
        dscType = {dsc[`PID_TYPE_HI_MSB:`PID_TYPE_HI_LSB], dsc[`PID_TYPE_LO_MSB:`PID_TYPE_LO_LSB]};
        domMask = pid_low_mask({2'h0, domWidth});
        gran_d = dsc[`PID_G_MSB:`PID_G_LSB];
        isPc_d = (dscType == `PID_TYPE_PC);
        isTlb_d = (dscType == `PID_TYPE_TLB);
        // Domain bits above the implemented width are dropped.
        domain_d = dsc[`PID_DID_MSB:`PID_DID_LSB] & domMask[15:0];
        pasid_d = dsc[`PID_PASID_MSB:`PID_PASID_LSB];
        readDrain_d = dsc[`PID_DR_BIT];
        writeDrain_d = dsc[`PID_DW_BIT];
        keepStage2_d = dsc[`PID_IH_BIT];
        addrMask_d = dsc[`PID_AM_MSB:`PID_AM_LSB];
        keepAddr = pid_low_mask(maxGuestAddrWidth);
        amMask = ~pid_low_mask(7'(`PID_PAGE_SHIFT + {1'b0, addrMask_d}));
        pageAddr_d = (dsc[`PID_ADDR_MSB:`PID_ADDR_LSB] & keepAddr[63:12] & amMask[63:12]);
        descOk_d = 1'b0;
        if (isPc_d) begin
            descOk_d = width256 && (gran_d != `PID_PC_RSVD);
            if (gran_d == `PID_PC_DOMAIN) begin
                pasid_d = 20'h0;
            end
            if (gran_d == `PID_PC_GLOBAL) begin
                domain_d = 16'h0;
                pasid_d = 20'h0;
            end
        end else if (isTlb_d) begin
            descOk_d = (gran_d != `PID_TLB_RSVD)
                && !(gran_d == `PID_TLB_PAGE && !psiSupport)
                && (!width256 || dsc[`PID_HALF_MSB:`PID_HALF_LSB] == 128'h0);
            pasid_d = 20'h0;
            if (gran_d != `PID_TLB_PAGE) begin
                pageAddr_d = 52'h0;
                addrMask_d = 6'h0;
                keepStage2_d = 1'b0;
            end
            if (gran_d == `PID_TLB_GLOBAL) begin
                domain_d = 16'h0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            isPc_q <= 1'b0;
            isTlb_q <= 1'b0;
            descOk_q <= 1'b0;
            gran_q <= 2'h0;
            domain_q <= 16'h0;
            pasid_q <= 20'h0;
            pageAddr_q <= 52'h0;
            addrMask_q <= 6'h0;
            keepStage2_q <= 1'b0;
            readDrain_q <= 1'b0;
            writeDrain_q <= 1'b0;
        end else if (load) begin
            isPc_q <= isPc_d;
            isTlb_q <= isTlb_d;
            descOk_q <= descOk_d;
            gran_q <= gran_d;
            domain_q <= domain_d;
            pasid_q <= pasid_d;
            pageAddr_q <= pageAddr_d;
            addrMask_q <= addrMask_d;
            keepStage2_q <= keepStage2_d;
            readDrain_q <= readDrain_d;
            writeDrain_q <= writeDrain_d;
        end
    end

    assign isPc = isPc_q;
    assign isTlb = isTlb_q;
    assign descOk = descOk_q;
    assign gran = gran_q;
    assign domain = domain_q;
    assign pasid = pasid_q;
    assign pageAddr = pageAddr_q;
    assign addrMask = addrMask_q;
    assign keepStage2 = keepStage2_q;
    assign readDrain = readDrain_q;
    assign writeDrain = writeDrain_q;

endmodule // pid_desc_check

// *** core/pid_inv_decoder.sv ***
// Chosen here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
`include "pid_cfg.svh"

// Functional notes
// - PASID-cache flush accepted only as 256-bit descriptor; 128-bit queue mode is invalid.
// - Type is bits 11:9 joined with bits 3:0; value 7h is PASID-cache flush.
// - PASID-cache granularity: 00 domain, 01 domain plus PASID, 11 everything.
// - PASID-cache granularity 10 marks the descriptor invalid.
// - Domain identifier bits above the implemented width are ignored.
// - PASID field ignored for domain-selective PASID-cache flush.
// - Hardware may invalidate more entries than the requested granularity asks.
// - IOTLB flush is 128-bit, zero padded in 256-bit mode; mismatch is invalid.
// - Type value 2h selects the IOTLB flush.
// - IOTLB granularity 01 drops every IOTLB and paging-structure entry.
// - IOTLB granularity 10 drops entries whose domain matches.
// - Without page-selective support, IOTLB granularity 11 is invalid.
// - Page-selective: type 010b or legacy entries match domain and range, others domain.
// - Page-selective: hint 0 drops second-stage structure entries in range, hint 1 keeps them.
// - IOTLB granularity 00 marks the descriptor invalid.
// - Drain flags set mean queued reads or writes drain before next wait completes.
// - Major version 2 or above ignores drain flags and always drains.
// - Global ignores domain; global and domain-selective ignore hint and address.
// - Address bits above the guest address width are ignored.
// - Mask k clears k address bits from bit 12, covering 2^k pages.
// - With write-buffer flush required, flush the write buffer before any IOTLB flush.
// - Queue head advances past a descriptor only once it is found valid.
module pid_inv_decoder
    import pid_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic dscValid,
    input wire logic [255:0] dscData,
    output logic dscReady,
    output logic headAdvance,
    output logic dscInvalid,
    input wire logic errClear,
    output logic pcInvValid,
    input wire logic pcInvReady,
    output logic [1:0] pcInvGran,
    output logic [15:0] pcInvDomain,
    output logic [19:0] pcInvPasid,
    output logic tlbInvValid,
    input wire logic tlbInvReady,
    output logic [1:0] tlbInvGran,
    output logic [15:0] tlbInvDomain,
    output logic [51:0] tlbInvPageAddr,
    output logic [5:0] tlbInvMask,
    output logic tlbInvKeepStage2,
    output logic tlbInvLegacyAll,
    output logic wbFlushReq,
    input wire logic wbFlushAck,
    output logic drainValid,
    input wire logic drainReady,
    output logic drainRead,
    output logic drainWrite
);
    pid_state_e state_q, state_d;
    logic [31:0] ctrl_q, ctrl_d, cap_q, cap_d, rdata_q, rdata_d;
    logic ack_q, ack_d, errPend_q, errPend_d;
    logic [15:0] doneCnt_q, doneCnt_d, badCnt_q, badCnt_d;
    logic drainRd_q, drainRd_d, drainWr_q, drainWr_d;
    logic decPc, decTlb, decOk, decKeep, decRd, decWr;
    logic [1:0] decGran;
    logic [15:0] decDomain;
    logic [19:0] decPasid;
    logic [51:0] decAddr;
    logic [5:0] decMask;
    logic busAccept, wrStatus;
    logic width256, psiSupport, write_buffer_flush_required, verDrain;

    assign width256 = ctrl_q[`PID_CTRL_W256];
    assign psiSupport = ctrl_q[`PID_CTRL_PSI];
    assign write_buffer_flush_required = ctrl_q[`PID_CTRL_WRITE_BUFFER_FLUSH_REQUIRED];
    assign verDrain = (ctrl_q[`PID_CTRL_VER_MSB:`PID_CTRL_VER_LSB] >= `PID_VER_DRAIN);

    pid_desc_check u_check (
        .core_clk(core_clk),
        .rst(rst),
        .load(state_q == ST_IDLE && dscValid),
        .dsc(dscData),
        .width256(width256),
        .psiSupport(psiSupport),
        .domWidth(cap_q[`PID_CAP_DOMW_MSB:`PID_CAP_DOMW_LSB]),
        .maxGuestAddrWidth(cap_q[`PID_CAP_MAX_GUEST_ADDR_WIDTH_MSB:`PID_CAP_MAX_GUEST_ADDR_WIDTH_LSB]),
        .isPc(decPc),
        .isTlb(decTlb),
        .descOk(decOk),
        .gran(decGran),
        .domain(decDomain),
        .pasid(decPasid),
        .pageAddr(decAddr),
        .addrMask(decMask),
        .keepStage2(decKeep),
        .readDrain(decRd),
        .writeDrain(decWr)
    );

    // Register bus: one wait cycle, then the access completes.
    assign busAccept = (avs_read || avs_write) && ack_q;
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign wrStatus = busAccept && avs_write && avs_address == `PID_REG_STATUS;

    always_comb begin
        ack_d = (avs_read || avs_write) && !ack_q;
        rdata_d = rdata_q;
        if (ack_d && avs_read) begin
            case (avs_address)
                `PID_REG_CTRL: rdata_d = ctrl_q;
                `PID_REG_STATUS: rdata_d = {30'h0, errPend_q, state_q != ST_IDLE};
                `PID_REG_CAP: rdata_d = cap_q | {10'h0, `PID_MAX_AM, 16'h0};
                `PID_REG_COUNT: rdata_d = {badCnt_q, doneCnt_q};
                default: rdata_d = 32'h0;
            endcase
        end
        ctrl_d = ctrl_q;
        cap_d = cap_q;
        if (busAccept && avs_write && avs_address == `PID_REG_CTRL) begin
            ctrl_d = pid_be_merge(ctrl_q, avs_writedata, avs_byteenable, `PID_CTRL_MASK);
        end
        if (busAccept && avs_write && avs_address == `PID_REG_CAP) begin
            cap_d = pid_be_merge(cap_q, avs_writedata, avs_byteenable, `PID_CAP_MASK);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0;
            ctrl_q <= `PID_CTRL_RESET;
            cap_q <= `PID_CAP_RESET;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            ctrl_q <= ctrl_d;
            cap_q <= cap_d;
        end
    end

    assign avs_readdata = rdata_q;

    // Descriptor sequencer.
    always_comb begin
        state_d = state_q;
        drainRd_d = drainRd_q;
        drainWr_d = drainWr_q;
        doneCnt_d = doneCnt_q;
        badCnt_d = badCnt_q;
        errPend_d = errPend_q;
        if (errClear || (wrStatus && avs_byteenable[0] && avs_writedata[`PID_STAT_ERR])) begin
            errPend_d = 1'b0;
        end
        case (state_q)
            ST_IDLE: begin
                if (dscValid) begin
                    state_d = ST_CHECK;
                end
            end
            ST_CHECK: begin
                drainRd_d = decRd || verDrain;
                drainWr_d = decWr || verDrain;
                if (!decOk || !(decPc || decTlb)) begin
                    state_d = ST_ERROR;
                    errPend_d = 1'b1;
                    badCnt_d = badCnt_q + 16'h1;
                end else if (decTlb && write_buffer_flush_required) begin
                    state_d = ST_FLUSH;
                end else begin
                    state_d = ST_ISSUE;
                end
            end
            ST_FLUSH: begin
                if (wbFlushAck) begin
                    state_d = ST_ISSUE;
                end
            end
            ST_ISSUE: begin
                if (decPc && pcInvReady) begin
                    state_d = ST_DONE;
                end else if (decTlb && tlbInvReady) begin
                    state_d = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (!(drainRd_q || drainWr_q) || drainReady) begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE: begin
                state_d = ST_IDLE;
                doneCnt_d = doneCnt_q + 16'h1;
            end
            ST_ERROR: begin
                if (!errPend_q) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            drainRd_q <= 1'b0;
            drainWr_q <= 1'b0;
            doneCnt_q <= 16'h0;
            badCnt_q <= 16'h0;
            errPend_q <= 1'b0;
        end else begin
            state_q <= state_d;
            drainRd_q <= drainRd_d;
            drainWr_q <= drainWr_d;
            doneCnt_q <= doneCnt_d;
            badCnt_q <= badCnt_d;
            errPend_q <= errPend_d;
        end
    end

    assign dscReady = (state_q == ST_DONE);
    assign headAdvance = (state_q == ST_DONE);
    assign dscInvalid = (state_q == ST_CHECK) && !(decOk && (decPc || decTlb));
    assign wbFlushReq = (state_q == ST_FLUSH);
    assign pcInvValid = (state_q == ST_ISSUE) && decPc;
    assign tlbInvValid = (state_q == ST_ISSUE) && decTlb;
    assign drainValid = (state_q == ST_DRAIN) && (drainRd_q || drainWr_q);
    assign drainRead = drainRd_q;
    assign drainWrite = drainWr_q;
    assign pcInvGran = decGran;
    assign pcInvDomain = decDomain;
    assign pcInvPasid = decPasid;
    assign tlbInvGran = decGran;
    assign tlbInvDomain = decDomain;
    // A mask beyond the reported maximum still clears its bits, widening the range.
    assign tlbInvPageAddr = decAddr;
    assign tlbInvMask = decMask;
    assign tlbInvKeepStage2 = decKeep;
    // Legacy mode makes every entry match on domain and range.
    assign tlbInvLegacyAll = (ctrl_q[`PID_CTRL_TTM_MSB:`PID_CTRL_TTM_LSB] == `PID_TTM_LEGACY);

    logic [63:0] maskLow;
    assign maskLow = pid_low_mask({1'b0, tlbInvMask});

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_invalid_no_side: assert property (dscInvalid |-> !headAdvance ##1 (!pcInvValid && !tlbInvValid) [*2])
        else $error("invalid descriptor produced an invalidation");
    a_head_after_valid: assert property ($rose(headAdvance) |-> !$past(errPend_q) && !$past(dscInvalid))
        else $error("head advanced without a valid descriptor");
    a_pc_wide_only: assert property (pcInvValid |-> width256)
        else $error("PASID-cache flush issued in 128-bit mode");
    a_pc_gran_legal: assert property (pcInvValid |-> pcInvGran != `PID_PC_RSVD)
        else $error("reserved PASID-cache granularity issued");
    a_pasid_dropped: assert property (pcInvValid && pcInvGran == `PID_PC_DOMAIN |-> pcInvPasid == 20'h0)
        else $error("PASID not ignored for domain granularity");
    a_tlb_gran_legal: assert property (tlbInvValid |-> tlbInvGran != `PID_TLB_RSVD
        && (tlbInvGran != `PID_TLB_PAGE || psiSupport))
        else $error("illegal IOTLB granularity issued");
    a_flush_before: assert property ($rose(tlbInvValid) && write_buffer_flush_required |-> $past(wbFlushReq && wbFlushAck))
        else $error("IOTLB flush without prior write-buffer flush");
    a_drain_follow: assert property (tlbInvValid && tlbInvReady && verDrain |=> drainValid && drainRead && drainWrite)
        else $error("drain not requested after IOTLB flush");
    a_global_clean: assert property (tlbInvValid && tlbInvGran != `PID_TLB_PAGE
        |-> tlbInvPageAddr == 52'h0 && !tlbInvKeepStage2)
        else $error("address or hint not ignored");
    a_mask_applied: assert property (tlbInvValid |-> (tlbInvPageAddr & maskLow[51:0]) == 52'h0)
        else $error("masked address bits not cleared");
    a_error_hold: assert property ($rose(errPend_q) |-> !headAdvance throughout (##[1:4] 1'b1))
        else $error("head advanced while error pending");

    c_pc_flush: cover property (pcInvValid && pcInvReady);
    c_tlb_page: cover property (tlbInvValid && tlbInvGran == `PID_TLB_PAGE && tlbInvReady);
    c_invalid: cover property (dscInvalid);
    c_drain: cover property (drainValid && drainReady);

endmodule // pid_inv_decoder

// *** verif/pid_queue_model.sv ***
`timescale 1ns/100ps

// Queue fetch side and cache acknowledgers, answering after a random stall of 0 to 3 cycles.
module pid_queue_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic pushValid,
    input wire logic [255:0] pushData,
    input wire logic headAdvance,
    input wire logic dscInvalid,
    input wire logic [3:0] reqValid,
    output logic dscValid,
    output logic [255:0] dscData,
    output logic [3:0] reqReady
);
    logic dscValid_q, dscValid_d;
    logic [255:0] data_q, data_d;
    logic [3:0] ready_q, ready_d;
    logic [1:0] stall_q;
    // A released descriptor bus shows the inverse of the last word.
    assign dscValid = dscValid_q;
    assign dscData = dscValid_q ? data_q : ~data_q;
    assign reqReady = ready_q;
    always_comb begin
        dscValid_d = dscValid_q;
        data_d = data_q;
        if (pushValid) begin
            dscValid_d = 1'b1;
            data_d = pushData;
        end else if (headAdvance || dscInvalid) begin
            dscValid_d = 1'b0;
        end
        ready_d = (stall_q == 2'h0) ? (reqValid & ~ready_q) : 4'h0;
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dscValid_q <= 1'b0;
            data_q <= 256'h0;
            ready_q <= 4'h0;
            stall_q <= 2'h0;
        end else begin
            dscValid_q <= dscValid_d;
            data_q <= data_d;
            ready_q <= ready_d;
            stall_q <= (stall_q == 2'h0) ? 2'($urandom_range(3)) : stall_q - 2'h1;
        end
    end
endmodule // pid_queue_model

// *** verif/test_pid_inv_decoder.sv ***
`timescale 1ns/100ps
`include "pid_cfg.svh"
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
    $display("MISMATCH %0t got %h exp %h", $time, got, exp); end end

module test_pid_inv_decoder;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] avs_address = 3'h0;
    logic avs_read = 1'b0, avs_write = 1'b0, errClear = 1'b0, pushValid = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rdata;
    logic [3:0] avs_byteenable = 4'hF, readies;
    logic [255:0] pushData = 256'h0, dscData;
    logic avs_waitrequest, dscValid, dscReady, headAdvance, dscInvalid, pcInvValid, tlbInvValid;
    logic wbFlushReq, drainValid, drainRead, drainWrite, tlbInvKeepStage2, tlbInvLegacyAll;
    logic [1:0] pcInvGran, tlbInvGran, pg, tg;
    logic [15:0] pcInvDomain, tlbInvDomain, dom;
    logic [19:0] pcInvPasid, pas;
    logic [51:0] tlbInvPageAddr, ad;
    logic [5:0] tlbInvMask, am;
    logic ih, dr, dw, cRwbf, cVer2, cLegacy;
    logic [127:0] expq[$];
    int failures = 0, samples_checked = 0, nDone = 0, nBad = 0;

    always #20 core_clk = ~core_clk;

    pid_inv_decoder pid_inv_decoder_i (.core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .dscValid, .dscData, .dscReady, .headAdvance,
        .dscInvalid, .errClear, .pcInvValid, .pcInvReady(readies[0]), .pcInvGran, .pcInvDomain, .pcInvPasid,
        .tlbInvValid, .tlbInvReady(readies[1]), .tlbInvGran, .tlbInvDomain, .tlbInvPageAddr, .tlbInvMask,
        .tlbInvKeepStage2, .tlbInvLegacyAll, .wbFlushReq, .wbFlushAck(readies[2]), .drainValid,
        .drainReady(readies[3]), .drainRead, .drainWrite);
    pid_queue_model pid_queue_model_i (.core_clk, .rst, .pushValid, .pushData, .headAdvance, .dscInvalid,
        .reqValid({drainValid, wbFlushReq, tlbInvValid, pcInvValid}), .dscValid, .dscData, .reqReady(readies));

    function automatic logic [255:0] mk(input logic [6:0] t, input logic [1:0] g, input logic r, w,
        input logic [15:0] d, input logic [19:0] p, input logic [5:0] m, input logic h, input logic [51:0] a);
        return {128'h0, a, 5'h0, h, m, 12'h0, p, d, 4'h0, t[6:4], 1'b0, r, w, g, t[3:0]};
    endfunction
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin @(posedge core_clk); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) failures++;
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rdata, e)
    endtask
    task automatic send(input logic [255:0] d, input logic bad);
        int n = 0;
        @(posedge core_clk);
        pushValid <= 1'b1;
        pushData <= d;
        @(posedge core_clk);
        pushValid <= 1'b0;
        do begin @(posedge core_clk); n++; end while (dscValid !== 1'b0 && n < 100);
        if (bad) begin
            errClear <= 1'b1;
            @(posedge core_clk);
            errClear <= 1'b0;
        end
        @(posedge core_clk);
    endtask
    task automatic fin();
        expq.push_back({4'h4, 123'h0, 1'b1});
        nDone++;
    endtask
    task automatic bad();
        expq.push_back({4'h3, 124'h0});
        nBad++;
    endtask
    task automatic pc(input logic [1:0] g);
        expq.push_back({4'h1, 86'h0, g, (g == 2'h3) ? 36'h0 : {dom, (g == 2'h0) ? 20'h0 : pas}});
        fin();
    endtask
    task automatic tlb(input logic [1:0] g);
        if (cRwbf) expq.push_back({4'h5, 124'h0});
        expq.push_back({4'h2, 46'h0, g, (g == 2'h1) ? 16'h0 : dom, (g == 2'h3) ?
            {ad & 52'h0_000F_FFFF_FFFF & ~((52'h1 << am) - 52'h1), am, ih} : 59'h0, cLegacy});
        if (dr || dw || cVer2) expq.push_back({4'h6, 122'h0, dr || cVer2, dw || cVer2});
        fin();
    endtask
    task automatic see(input logic [127:0] o);
        logic [127:0] e;
        if (expq.size() == 0) begin
            failures++;
            $display("MISMATCH %0t unexpected event %h", $time, o);
        end else begin
            e = expq.pop_front();
            `CHK(o, e)
        end
    endtask
    task automatic close_out();
        if (failures == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        if (!rst) begin
            if (pcInvValid && readies[0]) see({4'h1, 86'h0, pcInvGran, pcInvDomain,
                (pcInvGran == 2'h0) ? 20'h0 : pcInvPasid});
            if (tlbInvValid && readies[1]) see({4'h2, 46'h0, tlbInvGran, (tlbInvGran == 2'h1) ? 16'h0 : tlbInvDomain,
                (tlbInvGran == 2'h3) ? {tlbInvPageAddr, tlbInvMask, tlbInvKeepStage2} : 59'h0,
                tlbInvLegacyAll});
            if (wbFlushReq && readies[2]) see({4'h5, 124'h0});
            if (drainValid && readies[3]) see({4'h6, 122'h0, drainRead, drainWrite});
            if (dscInvalid) see({4'h3, 123'h0, headAdvance});
            if (dscReady) see({4'h4, 123'h0, headAdvance});
        end
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        failures++;
        close_out();
    end

    initial begin
        void'($urandom(41734));
        {cRwbf, cVer2, cLegacy} = 3'b001;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        rd(`PID_REG_CTRL, 32'h0000_0102);
        rd(`PID_REG_CAP, `PID_CAP_RESET | {10'h0, `PID_MAX_AM, 16'h0});
        bus(1'b1, 3'h5, 32'hFFFF_FFFF);
        rd(3'h5, 32'h0);
        bus(1'b1, `PID_REG_CTRL, 32'hFFFF_FFFF);
        rd(`PID_REG_CTRL, 32'h0000_0F37);
        bus(1'b1, `PID_REG_CTRL, 32'h0000_0102);
        {dom, pas, ad, ih, dr, dw} = {$urandom, $urandom, $urandom, $urandom};
        bad();
        send(mk(`PID_TYPE_PC, 2'h0, 1'b0, 1'b0, dom, pas, 6'h0, 1'b0, 52'h0), 1'b1);
        {dr, dw} = 2'b00;
        tlb(2'h1);
        send(mk(`PID_TYPE_TLB, 2'h1, 1'b0, 1'b0, dom, 20'h0, 6'h3, 1'b1, ad) | {128'(~$urandom), 128'h0}, 1'b0);
        bad();
        send(mk(`PID_TYPE_TLB, 2'h0, 1'b0, 1'b0, dom, 20'h0, 6'h0, 1'b0, ad), 1'b1);
        bus(1'b1, `PID_REG_CTRL, 32'h0000_0107);
        cRwbf = 1'b1;
        for (int i = 0; i < 3; i++) begin
            {dom, pas, ad, ih, dr, dw} = {$urandom, $urandom, $urandom, $urandom};
            pg = (i == 0) ? 2'h0 : (i == 1) ? 2'h3 : 2'h1;
            tg = (i == 0) ? 2'h2 : (i == 1) ? 2'h1 : 2'h3;
            am = (i == 0) ? 6'h0 : (i == 1) ? 6'h9 : 6'h12;
            pc(pg);
            send(mk(`PID_TYPE_PC, pg, 1'b0, 1'b0, dom, pas, 6'h0, 1'b0, 52'h0), 1'b0);
            tlb(tg);
            send(mk(`PID_TYPE_TLB, tg, dr, dw, dom, 20'h0, am, ih, ad), 1'b0);
        end
        bad();
        send(mk(`PID_TYPE_PC, 2'h2, 1'b0, 1'b0, dom, pas, 6'h0, 1'b0, 52'h0), 1'b1);
        bad();
        send(mk(`PID_TYPE_TLB, 2'h1, 1'b0, 1'b0, dom, 20'h0, 6'h0, 1'b0, ad) | {1'b1, 255'h0}, 1'b1);
        bad();
        send(mk(7'h12, 2'h1, 1'b0, 1'b0, dom, 20'h0, 6'h0, 1'b0, ad), 1'b1);
        bus(1'b1, `PID_REG_CTRL, 32'h0000_0215);
        {cRwbf, cVer2, cLegacy} = 3'b110;
        bad();
        send(mk(`PID_TYPE_TLB, 2'h3, 1'b0, 1'b0, dom, 20'h0, 6'h0, 1'b0, ad), 1'b0);
        rd(`PID_REG_STATUS, 32'h0000_0003);
        bus(1'b1, `PID_REG_STATUS, 32'h0000_0002);
        bus(1'b1, `PID_REG_CAP, 32'h0000_3008);
        dom = dom & 16'h00FF;
        {dr, dw} = 2'b00;
        tlb(2'h2);
        send(mk(`PID_TYPE_TLB, 2'h2, 1'b0, 1'b0, dom | 16'h5A00, 20'h0, 6'h0, 1'b0, ad), 1'b0);
        rd(`PID_REG_COUNT, {16'(nBad), 16'(nDone)});
        `CHK(32'(expq.size()), 32'h0)
        close_out();
    end
endmodule // test_pid_inv_decoder
